// [inc/uswm_pkg.sv]
/*
 * Constants shared by the sleep/wake and infrared carrier block: register
 * offsets, field positions, reset values, state codes and cycle counts.
 * Assumes a 32-bit classic Wishbone register bus with byte addressing.
 */
package uswm_pkg;

    // ************************************************************
    // Register map (byte addresses, one aligned word each)
    // ************************************************************
    localparam logic [3:0] OFS_CARRIER_CONFIG = 4'h0;
    localparam logic [3:0] OFS_CARRIER_ROUTE  = 4'h4;
    localparam logic [3:0] OFS_WAKE_CTRL      = 4'h8;
    localparam logic [3:0] OFS_SLEEP_STATE    = 4'hc;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int POS_POLARITY_SEL = 7;
    localparam int DIVIDER_W        = 7;
    localparam int POS_TX_CARRIER   = 0;
    localparam int POS_WAKE_EN      = 0;
    localparam int POS_PORT_EN      = 1;
    localparam int POS_RX_ON        = 2;
    localparam int POS_RX_IRQ_EN    = 3;
    localparam int POS_GLOBAL_IRQ   = 4;
    localparam int POS_SERIAL_IRQ   = 5;
    localparam int POS_ST_SLEEPING  = 0;
    localparam int POS_ST_STARTING  = 1;
    localparam int POS_ST_CLK_RUN   = 2;

    // ************************************************************
    // Values after reset
    // ************************************************************
    localparam logic [7:0] RST_CARRIER_CONFIG = 8'h00;
    localparam logic [7:0] RST_CARRIER_ROUTE  = 8'h00;
    localparam logic [5:0] RST_WAKE_CTRL      = 6'h00;

    // ************************************************************
    // Counts
    // ************************************************************
    localparam int STARTUP_CNT_W    = 16;
    localparam int STARTUP_CYCLES_D = 1024;

    // ************************************************************
    // Power state machine
    // ************************************************************
    typedef enum logic [2:0] {
        PS_RUN   = 3'b001,
        PS_SLEEP = 3'b010,
        PS_START = 3'b100
    } uswm_pstate_e;

endpackage

// [inc/uswm_if.sv]
/*
 * Carrier and power bundle between the top module, the carrier generator and the
 * power sequencer. Assumes all three parties share one clock.
 */
`timescale 1ns/1ps
interface uswm_if;
    import uswm_pkg::*;

    logic [DIVIDER_W-1:0] divider;
    logic                 polarity_sel;
    logic                 carrier_en;
    logic                 hold;
    logic                 tx_data;
    logic                 tx_mod;
    logic                 sleep_req;
    logic                 rx_fall;
    logic                 wake_armed;
    logic                 irq_allowed;
    logic                 sleeping;
    logic                 starting;
    logic                 wake_pulse;
    logic                 irq_pulse;

    modport carrier (
        input  divider,
        input  polarity_sel,
        input  carrier_en,
        input  hold,
        input  tx_data,
        output tx_mod
    );

    modport power (
        input  sleep_req,
        input  rx_fall,
        input  wake_armed,
        input  irq_allowed,
        output sleeping,
        output starting,
        output wake_pulse,
        output irq_pulse
    );

endinterface

// [rtl/uswm_carrier.sv]
/*
 * Infrared carrier generator and transmit modulator.
 * Assumes transmit data comes from logic on the same clock.
 */
`timescale 1ns/1ps
module uswm_carrier
    import uswm_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    uswm_if.carrier   cr
);

    logic [DIVIDER_W-1:0] cnt_reg;
    logic                 carrier_reg;

    // ************************************************************
    // Carrier counter
    // ************************************************************
    // Reload and toggle at zero: half period is divider+1 cycles
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_reg     <= '0;
            carrier_reg <= 1'b0;
        end
        else if (!cr.hold)
        begin
            if (cnt_reg == '0)
            begin
                cnt_reg     <= cr.divider;   // [RULE10] [RULE11] [RULE19]
                carrier_reg <= ~carrier_reg; // [RULE19]
            end
            else
            begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end

    // ************************************************************
    // Modulator
    // ************************************************************
    // Carrier only on a low bit, polarity flips the output only while modulating
    always_comb
    begin
        if (cr.carrier_en) // [RULE15]
        begin
            cr.tx_mod = (cr.tx_data ? 1'b0 : carrier_reg) ^ cr.polarity_sel; // [RULE12] [RULE13] [RULE20]
        end
        else
        begin
            cr.tx_mod = cr.tx_data; // [RULE18]
        end
    end

endmodule // uswm_carrier

// [rtl/uswm_power.sv]
/*
 * Power sequencer: sleep, receive-pin wake and start-up delay.
 * Assumes the processor drops its sleep request once it sees a wake.
 */
`timescale 1ns/1ps
module uswm_power
    import uswm_pkg::*;
#(
    parameter int STARTUP_CYCLES = STARTUP_CYCLES_D
)
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    uswm_if.power     pw
);

    uswm_pstate_e             state_reg;
    uswm_pstate_e             state_next;
    logic [STARTUP_CNT_W-1:0] wait_reg;
    logic                     by_rx_reg;
    logic                     rx_wake;

    // Rx wake only counts while armed and asleep
    assign rx_wake = pw.rx_fall && pw.wake_armed; // [RULE6]

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            PS_RUN:
            begin
                if (pw.sleep_req)
                begin
                    state_next = PS_SLEEP;
                end
            end
            PS_SLEEP:
            begin
                if (rx_wake || !pw.sleep_req)
                begin
                    state_next = PS_START;
                end
            end
            PS_START:
            begin
                if (wait_reg == '0 && !pw.sleep_req)
                begin
                    state_next = PS_RUN;
                end
            end
            default:
            begin
                state_next = PS_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= PS_RUN;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ************************************************************
    // Start-up wait and wake source
    // ************************************************************
    // Loaded on wake so the core stays frozen the full period
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wait_reg  <= '0;
            by_rx_reg <= 1'b0;
        end
        else if (state_reg == PS_SLEEP && state_next == PS_START)
        begin
            wait_reg  <= STARTUP_CNT_W'(STARTUP_CYCLES - 1);
            by_rx_reg <= rx_wake;
        end
        else if (state_reg == PS_START && wait_reg != '0)
        begin
            wait_reg <= wait_reg - 1'b1; // [RULE9]
        end
    end

    assign pw.sleeping   = (state_reg == PS_SLEEP);
    assign pw.starting   = (state_reg == PS_START);
    assign pw.wake_pulse = pw.sleeping && rx_wake; // [RULE6]
    // Wake interrupt only after start-up and only if enabled
    assign pw.irq_pulse  = pw.starting && state_next == PS_RUN && by_rx_reg && pw.irq_allowed; // [RULE8] [RULE9]

endmodule // uswm_power

// [rtl/uswm_top.sv]
/*
 * Top of the serial sleep/wake and infrared modulator block, with its
 * Wishbone register slave, receive pin synchroniser and output stage.
 * Assumes a classic Wishbone master and a serial core on the same clock
 * that stops shifting while port_clk_run_o is low.
 */
// Implementation choices: the Wishbone slave port and the address map.
// How it works
// [RULE1] Power-down stops the serial port clock; the port does nothing meanwhile.
// [RULE2] A transmit under way freezes at its bit and resumes with the clock.
// [RULE3] A receive under way freezes likewise and resumes with the clock.
// [RULE4] Power-down leaves all serial and carrier registers untouched.
// [RULE5] Software should let transfers finish before requesting power-down.
// [RULE6] Falling rx edge wakes if wake, port, receiver and rx-irq enables set.
// [RULE7] Rx data during start-up after wake is discarded.
// [RULE8] Wake interrupt needs global and serial interrupt enables too.
// [RULE9] Wake interrupt waits until the start-up period has fully elapsed.
// [RULE10] Carrier divider is seven bits, any value 0 to 127.
// [RULE11] Carrier frequency is clock over divider plus one, halved.
// [RULE12] Carrier reaches the output only while the transmit bit is low.
// [RULE13] Polarity select in bit 7 inverts the modulated output.
// [RULE14] Polarity encodings conflict; zero means positive, one inverts.
// [RULE15] Route bit 0 enables infrared modulation of transmit output.
// [RULE16] Route bits 7 to 1 always read zero.
// [RULE17] Rx wake has no status flag; only the shared interrupt shows it.
// [RULE18] Modulation off passes transmit data unchanged to the pin.
// [RULE19] Counter reloads from divider, toggling carrier at terminal count.
// [RULE20] High transmit bit with modulation on sits at the polarity idle level.
`timescale 1ns/1ps
module uswm_top
    import uswm_pkg::*;
#(
    parameter int STARTUP_CYCLES = STARTUP_CYCLES_D
)
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        sleep_req_i,
    input  wire logic        tx_data_i,
    input  wire logic        rx_pin_i,
    output logic             tx_pin_o,
    output logic             rx_core_o,
    output logic             port_clk_run_o,
    output logic             wake_o,
    output logic             uart_irq_o
);

    // Refuse start-up counts below 1 or above 65535
    if (STARTUP_CYCLES < 1 || STARTUP_CYCLES >= (1 << STARTUP_CNT_W))
    begin : g_bad_startup
        $error("STARTUP_CYCLES out of range");
    end

    uswm_if bus ();

    logic [7:0] config_reg;
    logic       route_reg;
    logic [5:0] wake_ctrl_reg;
    logic       req;
    logic       wr_commit;
    logic [31:0] rd_next;
    logic       rx_meta_reg;
    logic       rx_s2_reg;
    logic       rx_s3_reg;
    logic       rx_lvl_reg;

    // ************************************************************
    // Wishbone slave
    // ************************************************************
    // Ack one cycle after the request; write lands on the ack edge
    assign req       = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_commit = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= req;
        end
    end

    // Read mux; the low two address bits are ignored, so every offset reads the register of its word
    always_comb
    begin
        rd_next = 32'h0000_0000;
        unique case (wb_adr_i & 4'hc)
            OFS_CARRIER_CONFIG: rd_next[7:0] = config_reg;
            OFS_CARRIER_ROUTE:  rd_next[POS_TX_CARRIER] = route_reg; // [RULE16]
            OFS_WAKE_CTRL:      rd_next[5:0] = wake_ctrl_reg;
            OFS_SLEEP_STATE:
            begin
                // No rx-wake flag here, by design [RULE17]
                rd_next[POS_ST_SLEEPING] = bus.sleeping;
                rd_next[POS_ST_STARTING] = bus.starting;
                rd_next[POS_ST_CLK_RUN]  = port_clk_run_o;
            end
            default:            rd_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_dat_o <= 32'h0000_0000;
        end
        else if (req && !wb_we_i)
        begin
            wb_dat_o <= rd_next;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    // Only bus writes change these; sleep never touches them
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            config_reg    <= RST_CARRIER_CONFIG;
            route_reg     <= RST_CARRIER_ROUTE[POS_TX_CARRIER];
            wake_ctrl_reg <= RST_WAKE_CTRL;
        end
        else if (wr_commit) // [RULE4]
        begin
            if (wb_adr_i[3:2] == OFS_CARRIER_CONFIG[3:2])
            begin
                config_reg <= wb_dat_i[7:0]; // [RULE10]
            end
            if (wb_adr_i[3:2] == OFS_CARRIER_ROUTE[3:2])
            begin
                route_reg <= wb_dat_i[POS_TX_CARRIER]; // [RULE15]
            end
            if (wb_adr_i[3:2] == OFS_WAKE_CTRL[3:2])
            begin
                wake_ctrl_reg <= wb_dat_i[5:0];
            end
        end
    end

    // ************************************************************
    // Receive pin synchroniser
    // ************************************************************
    // Three stages; a change counts once stages two and three agree
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rx_meta_reg <= 1'b1;
            rx_s2_reg   <= 1'b1;
            rx_s3_reg   <= 1'b1;
            rx_lvl_reg  <= 1'b1;
        end
        else
        begin
            rx_meta_reg <= rx_pin_i;
            rx_s2_reg   <= rx_meta_reg;
            rx_s3_reg   <= rx_s2_reg;
            if (rx_s2_reg == rx_s3_reg)
            begin
                rx_lvl_reg <= rx_s3_reg;
            end
        end
    end

    // ************************************************************
    // Sub-blocks
    // ************************************************************
    assign bus.divider      = config_reg[DIVIDER_W-1:0];                       // [RULE11]
    assign bus.polarity_sel = config_reg[POS_POLARITY_SEL];                    // [RULE13] [RULE14]
    assign bus.carrier_en   = route_reg;
    assign bus.hold         = !port_clk_run_o;                                 // [RULE1]
    assign bus.tx_data      = tx_data_i;
    assign bus.sleep_req    = sleep_req_i;
    assign bus.rx_fall      = rx_lvl_reg && (rx_s2_reg == rx_s3_reg) && !rx_s3_reg;
    assign bus.wake_armed   = wake_ctrl_reg[POS_WAKE_EN] && wake_ctrl_reg[POS_PORT_EN]
                              && wake_ctrl_reg[POS_RX_ON] && wake_ctrl_reg[POS_RX_IRQ_EN]; // [RULE6]
    assign bus.irq_allowed  = wake_ctrl_reg[POS_GLOBAL_IRQ] && wake_ctrl_reg[POS_SERIAL_IRQ]; // [RULE8]

    uswm_carrier u_carrier (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .cr    (bus.carrier)
    );

    uswm_power #(
        .STARTUP_CYCLES (STARTUP_CYCLES)
    ) u_power (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .pw    (bus.power)
    );

    // ************************************************************
    // Output stage
    // ************************************************************
    // Port clock runs only in the run state, so a frame in flight freezes
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            port_clk_run_o <= 1'b1;
            rx_core_o      <= 1'b1;
            tx_pin_o       <= 1'b1;
            wake_o         <= 1'b0;
            uart_irq_o     <= 1'b0;
        end
        else
        begin
            port_clk_run_o <= !bus.sleeping && !bus.starting && !sleep_req_i;   // [RULE1] [RULE2] [RULE3]
            rx_core_o      <= (bus.sleeping || bus.starting) ? 1'b1 : rx_lvl_reg; // [RULE7]
            tx_pin_o       <= bus.tx_mod;                                       // [RULE18]
            wake_o         <= bus.wake_pulse;                                   // [RULE6]
            uart_irq_o     <= bus.irq_pulse;                                    // [RULE8] [RULE9]
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_armed_fall;
        bus.sleeping && bus.rx_fall && bus.wake_armed;
    endsequence

    // Quiet from the wake cycle through the eighth start-up cycle
    sequence s_wake_then_quiet;
        (wake_o && !uart_irq_o) ##1 !uart_irq_o [*7];
    endsequence

    chk_clock_stopped: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
        $past(bus.sleeping) |-> !port_clk_run_o)
        else $error("port clock running in sleep");

    chk_regs_kept: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE4]
        (bus.sleeping && !wr_commit) |=> ($stable(config_reg) && $stable(route_reg) && $stable(wake_ctrl_reg)))
        else $error("register changed during sleep");

    chk_wake_edge: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
        s_armed_fall |=> wake_o ##1 !port_clk_run_o)
        else $error("armed falling edge did not wake");

    chk_wake_unarmed: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
        (bus.sleeping && !bus.wake_armed) |=> !wake_o)
        else $error("wake without all enables");

    chk_rx_discard: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
        $past(bus.starting) |-> rx_core_o)
        else $error("rx data passed during start-up");

    chk_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
        uart_irq_o |-> ($past(bus.irq_allowed) && $past(bus.starting)))
        else $error("wake interrupt without enables");

    chk_irq_late: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE9]
        (STARTUP_CYCLES >= 8) && $rose(wake_o) |-> s_wake_then_quiet)
        else $error("wake interrupt before start-up end");

    chk_route_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE16]
        $past(req && !wb_we_i && wb_adr_i[3:2] == OFS_CARRIER_ROUTE[3:2]) |-> wb_dat_o[31:1] == '0)
        else $error("route upper bits not zero");

    chk_tx_bypass: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE18]
        !route_reg |=> tx_pin_o == $past(tx_data_i))
        else $error("bypass transmit data altered");

    chk_idle_level: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE20]
        (route_reg && tx_data_i) |=> tx_pin_o == $past(config_reg[POS_POLARITY_SEL]))
        else $error("idle level not the polarity level");

endmodule // uswm_top

// [bench/uswm_line_model.sv]
/*
 * Remote serial transceiver on the receive wire of the block.
 * Assumes the bench raises send_i only while the block is powered down.
 */
`timescale 1ns/1ps
// ************************************************************
// Line model
// ************************************************************
module uswm_line_model
(
    input  wire logic clk_i,
    input  wire logic send_i,
    output logic      rx_o
);
    logic [3:0] pat_reg;
    // Mark level when idle; frames start low, then the bits keep changing
    always_ff @(posedge clk_i)
    begin
        pat_reg <= send_i ? {pat_reg[2:0], ~pat_reg[3]} : 4'h0;
        rx_o    <= send_i ? pat_reg[3] : 1'b1;
    end
endmodule // uswm_line_model

// [bench/tb.sv]
/*
 * Self-checking bench: register access, bypass, carrier and sleep/wake.
 * Assumes the block's start-up count is shortened to 8 cycles.
 */
`timescale 1ns/1ps
module tb;
    import uswm_pkg::*;
    localparam int SU = 8;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [3:0]  wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        wb_ack_o, sleep_req_i, tx_data_i, rx_pin_i, tx_pin_o;
    logic        rx_core_o, port_clk_run_o, wake_o, uart_irq_o, send;
    logic [7:0]  lfsr = 8'h45;
    int          mismatches = 0;
    int          check_count = 0;

    uswm_top #(.STARTUP_CYCLES(SU)) u_uswm_top (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .sleep_req_i(sleep_req_i), .tx_data_i(tx_data_i), .rx_pin_i(rx_pin_i),
        .tx_pin_o(tx_pin_o), .rx_core_o(rx_core_o), .port_clk_run_o(port_clk_run_o),
        .wake_o(wake_o), .uart_irq_o(uart_irq_o));
    uswm_line_model u_uswm_line_model (.clk_i(clk_i), .send_i(send), .rx_o(rx_pin_i));

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [7:0] nxt(input logic [7:0] l);
        return {l[6:0], l[7] ^ l[5] ^ l[4] ^ l[3]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Classic single cycle; only the watchdog ends a wait for ack
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d, output logic [31:0] rd);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hf;
        wb_dat_i <= d;
        do
        begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wreg(input logic [3:0] adr, input logic [31:0] d);
        logic [31:0] rd;
        wb(1'b1, adr, d, rd);
    endtask

    task automatic rreg(input logic [3:0] adr, input logic [31:0] exp);
        logic [31:0] rd;
        wb(1'b0, adr, 32'h0, rd);
        check(rd, exp);
    endtask

    // Cycles until the pin next changes, sampled on falling edges
    task automatic half(output int n);
        logic p;
        n = 0;
        p = tx_pin_o;
        do
        begin
            @(negedge clk_i);
            n++;
        end while (tx_pin_o === p && n < 300);
    endtask

    // Power-down with given enables; a remote frame arrives while asleep
    task automatic sleep_run(input logic [5:0] ctl, input logic wk, input logic irq);
        int n;
        int at;
        int cnt;
        wreg(OFS_WAKE_CTRL, {26'h0, ctl});
        @(posedge clk_i);
        sleep_req_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        check(port_clk_run_o, 1'b0);
        rreg(OFS_CARRIER_CONFIG, 32'h85);
        rreg(OFS_WAKE_CTRL, {26'h0, ctl});
        @(posedge clk_i);
        send <= 1'b1;
        n = 0;
        while (wake_o !== 1'b1 && n < 12)
        begin
            @(posedge clk_i);
            n++;
        end
        check(n < 12, wk);
        sleep_req_i <= 1'b0;
        n = 0;
        at = 0;
        cnt = 0;
        while (port_clk_run_o !== 1'b1 && n < 60)
        begin
            @(posedge clk_i);
            n++;
            if (uart_irq_o === 1'b1)
            begin
                at = n;
                cnt++;
            end
            if (port_clk_run_o !== 1'b1)
                check(rx_core_o, 1'b1);
        end
        send <= 1'b0;
        check(cnt, irq);
        if (irq)
            check(at >= SU, 1'b1);
        rreg(OFS_SLEEP_STATE, 32'h4);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ************************************************************
    // Clock, watchdog, main sequence
    // ************************************************************
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Run needs about a thousand cycles; allow thirty times that
    initial
    begin
        repeat (30000) @(posedge clk_i);
        mismatches++;
        final_report;
    end

    initial
    begin
        int h1;
        int h2;
        logic [6:0] dv [4];
        {wb_cyc_i, wb_stb_i, wb_we_i, sleep_req_i, send} = 5'h0;
        {wb_adr_i, wb_dat_i} = 36'h0;
        wb_sel_i = 4'hf;
        tx_data_i = 1'b1;
        rst_i = 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rreg(OFS_CARRIER_CONFIG, 32'h0);
        rreg(OFS_CARRIER_ROUTE, 32'h0);
        wreg(OFS_CARRIER_ROUTE, 32'hff);
        rreg(OFS_CARRIER_ROUTE, 32'h1);
        wreg(OFS_CARRIER_ROUTE, 32'h0);
        // Bypass copies transmit data one cycle late
        repeat (16)
        begin
            lfsr = nxt(lfsr);
            @(posedge clk_i);
            tx_data_i <= lfsr[0];
            @(posedge clk_i);
            @(negedge clk_i);
            check(tx_pin_o, lfsr[0]);
        end
        // Divider limits and a random value, both polarities
        dv = '{7'h0, 7'h1, 7'h7f, lfsr[6:0]};
        wreg(OFS_CARRIER_ROUTE, 32'h1);
        for (int k = 0; k < 4; k++)
        begin
            wreg(OFS_CARRIER_CONFIG, {24'h0, k[0], dv[k]});
            tx_data_i <= 1'b0;
            // Skip the data edge and the half period left over from the old divider
            repeat (3) half(h1);
            half(h2);
            check(h1, dv[k] + 1);
            check(h2, h1);
            @(posedge clk_i);
            tx_data_i <= 1'b1;
            repeat (2) @(negedge clk_i);
            repeat (8)
            begin
                @(negedge clk_i);
                check(tx_pin_o, k[0]);
            end
        end
        wreg(OFS_CARRIER_ROUTE, 32'h0);
        wreg(OFS_CARRIER_CONFIG, 32'h85);
        // Transmit left idle before each power-down
        sleep_run(6'h3f, 1'b1, 1'b1);
        sleep_run(6'h0f, 1'b1, 1'b0);
        sleep_run(6'h3e, 1'b0, 1'b0);
        sleep_run(6'h35, 1'b0, 1'b0);
        final_report;
    end
endmodule // tb
